// *** logic/itts_top.v ***
// Purpose: timestamps input transitions, per input or queued, with APB access
// Assumes: inputs already synchronous and filtered; time base supplied from outside
// Notes:   mode is latched only when software applies a configuration
`timescale 1ns/1ns
`include "itts_regs.vh"

// Summary of operation
// - per-input mode keeps exactly one rising and one falling timestamp per input.
// - rising and falling stamps of one input are stored by separate registers, so neither overwrites the other.
// - after reset and with no format chosen the block runs in per-input mode.
// - queued mode stamps enabled transitions of every input, one pending per input; a second edge before its push overwrites it.
// - queued entries go into a buffer and are read back in push order; among pending inputs the lowest is pushed first.
// - the buffer holds up to 160 entries.
// - the mode changes only when the controller applies a configuration with a format.
// - each input has its own rising and falling capture enable.
// - an enabled transition captures the time and sends an input data update.
// - after defaults are applied both capture enables of every input are set.
// - with no change inside the interval the input data is still sent once per interval.
module itts_top #(
    parameter N    = 16,
    parameter TW   = 32,
    parameter AW   = 8
) (
    input  wire          core_clk_in,
    input  wire          nrst_in,
    input  wire [N-1:0]  inputs_in,
    input  wire [TW-1:0] system_time_stamp_in,
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [11:0]   paddr,
    input  wire [31:0]   pwdata,
    output reg  [31:0]   prdata,
    output reg           pready,
    output reg           pslverr,
    output reg  [N-1:0]  data_out,
    output reg           data_update_out,
    output reg           irq_out
);
    localparam EW    = 1 + 4 + TW;    // polarity, input index, time
    localparam DEPTH = `ITTS_FIFO_DEPTH;

    reg           mode_r;
    reg  [N-1:0]  rise_en_r;
    reg  [N-1:0]  fall_en_r;
    reg  [31:0]   interval_r;
    reg  [31:0]   tick_r;
    reg  [N-1:0]  prev_r;
    reg           ovf_r;
    reg  [`ITTS_INT_W-1:0] int_stat_r;
    reg  [`ITTS_INT_W-1:0] int_en_r;
    reg  [TW-1:0] rise_ts_r [0:N-1];
    reg  [TW-1:0] fall_ts_r [0:N-1];
    reg  [N-1:0]  pend_r;              // queued events not yet pushed
    reg  [N-1:0]  pend_pol_r;
    reg  [TW-1:0] pend_ts_r [0:N-1];
    reg  [N-1:0]  pend_nxt;
    reg  [3:0]    sel_nxt;
    reg           sel_vld_nxt;
    reg  [31:0]   rd_nxt;
    reg           pop_r;
    reg           flush_r;

    wire [N-1:0]  rise_hit = inputs_in & ~prev_r & rise_en_r;
    wire [N-1:0]  fall_hit = ~inputs_in & prev_r & fall_en_r;
    wire [N-1:0]  any_hit  = rise_hit | fall_hit;
    wire          wr_acc   = psel & penable & pwrite & pready; // writes land only on the completing edge
    wire          tick_due = (tick_r >= interval_r - 32'h00000001);
    wire [EW-1:0] head;
    wire [AW:0]   fcount;
    wire          ffull;
    wire          fempty;
    wire          push     = sel_vld_nxt & ~ffull & (mode_r == `ITTS_MODE_QUEUED);
    wire [EW-1:0] push_data = {pend_pol_r[sel_nxt], sel_nxt, pend_ts_r[sel_nxt]};
    wire          drop     = sel_vld_nxt & ffull & (mode_r == `ITTS_MODE_QUEUED);
    integer       k;

    itts_fifo #(
        .WIDTH (EW),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_fifo (
        .core_clk_in  (core_clk_in),
        .nrst_in      (nrst_in),
        .flush_in     (flush_r),
        .push_in      (push),
        .push_data_in (push_data),
        .pop_in       (pop_r),
        .head_out     (head),
        .count_out    (fcount),
        .full_out     (ffull),
        .empty_out    (fempty)
    );

    // lowest pending input goes first; one push per clock, so a later edge of a lower input can pass an earlier one of a higher input
    always @*
    begin
        sel_nxt     = 4'h0;
        sel_vld_nxt = 1'b0;
        for (k = N - 1; k >= 0; k = k - 1)
            if (pend_r[k])
            begin
                sel_nxt     = k[3:0];
                sel_vld_nxt = 1'b1;
            end
        pend_nxt = pend_r;
        if (sel_vld_nxt)
            pend_nxt[sel_nxt] = 1'b0;
    end

    // per-input capture; rise and fall registers are separate so neither overwrites the other
    genvar g;
    generate
        for (g = 0; g < N; g = g + 1)
        begin : g_cap
            always @(posedge core_clk_in or negedge nrst_in)
            begin
                if (!nrst_in)
                begin
                    rise_ts_r[g] <= {TW{1'b0}};
                    fall_ts_r[g] <= {TW{1'b0}};
                    pend_ts_r[g] <= {TW{1'b0}};
                end
                else
                begin
                    if (rise_hit[g] && mode_r == `ITTS_MODE_PER_INPUT)
                        rise_ts_r[g] <= system_time_stamp_in;
                    if (fall_hit[g] && mode_r == `ITTS_MODE_PER_INPUT)
                        fall_ts_r[g] <= system_time_stamp_in;
                    if (any_hit[g] && mode_r == `ITTS_MODE_QUEUED)
                        pend_ts_r[g] <= system_time_stamp_in;
                end
            end
        end
    endgenerate

    // queue staging; a second edge of the same input before push overwrites its slot
    always @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            pend_r     <= {N{1'b0}};
            pend_pol_r <= {N{1'b0}};
            ovf_r      <= 1'b0;
        end
        else
        begin
            if (mode_r == `ITTS_MODE_QUEUED)
            begin
                pend_r     <= pend_nxt | any_hit;
                pend_pol_r <= (pend_pol_r & ~any_hit) | rise_hit;
            end
            else
                pend_r <= {N{1'b0}};
            if (drop)
                ovf_r <= 1'b1;
            else if (fempty)
                ovf_r <= 1'b0;
        end
    end

    // configuration, input data and periodic update
    always @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            mode_r          <= `ITTS_MODE_PER_INPUT;
            rise_en_r       <= {N{1'b1}};
            fall_en_r       <= {N{1'b1}};
            interval_r      <= `ITTS_INTERVAL_RST;
            tick_r          <= 32'h00000000;
            prev_r          <= {N{1'b0}};
            data_out        <= {N{1'b0}};
            data_update_out <= 1'b0;
            flush_r         <= 1'b0;
        end
        else
        begin
            prev_r  <= inputs_in;
            flush_r <= 1'b0;
            if (wr_acc && paddr == `ITTS_OFF_CTRL && pwdata[`ITTS_CTRL_APPLY_BIT])
            begin
                mode_r    <= pwdata[`ITTS_CTRL_MODE_BIT];
                rise_en_r <= {N{1'b1}};
                fall_en_r <= {N{1'b1}};
                flush_r   <= 1'b1;
            end
            else if (wr_acc && paddr == `ITTS_OFF_RISE_EN)
                rise_en_r <= pwdata[N-1:0];
            else if (wr_acc && paddr == `ITTS_OFF_FALL_EN)
                fall_en_r <= pwdata[N-1:0];
            else if (wr_acc && paddr == `ITTS_OFF_INTERVAL)
                interval_r <= (pwdata == 32'h00000000) ? 32'h00000001 : pwdata;
            // an enabled change sends data now and restarts the interval
            data_update_out <= (|any_hit) | tick_due;
            data_out        <= inputs_in;
            if ((|any_hit) || tick_due)
                tick_r <= 32'h00000000;
            else
                tick_r <= tick_r + 32'h00000001;
        end
    end

    // interrupt status: set wins over a clear in the same cycle
    always @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            int_stat_r <= {`ITTS_INT_W{1'b0}};
            int_en_r   <= {`ITTS_INT_W{1'b0}};
            irq_out    <= 1'b0;
        end
        else
        begin
            int_stat_r <= (int_stat_r
                          & ~((wr_acc && paddr == `ITTS_OFF_INT_CLR) ? pwdata[`ITTS_INT_W-1:0]
                                                                     : {`ITTS_INT_W{1'b0}}))
                          | {drop, |any_hit, ((|any_hit) | tick_due)};
            if (wr_acc && paddr == `ITTS_OFF_INT_EN)
                int_en_r <= pwdata[`ITTS_INT_W-1:0];
            irq_out <= |(int_stat_r & int_en_r);
        end
    end

    // read mux; time base window holds rise stamps then fall stamps
    always @*
    begin
        rd_nxt = 32'h00000000;
        case (paddr)
            `ITTS_OFF_CTRL:      rd_nxt = {31'h00000000, mode_r};
            `ITTS_OFF_RISE_EN:   rd_nxt[N-1:0] = rise_en_r;
            `ITTS_OFF_FALL_EN:   rd_nxt[N-1:0] = fall_en_r;
            `ITTS_OFF_INTERVAL:  rd_nxt = interval_r;
            `ITTS_OFF_STATUS:    rd_nxt = {30'h00000000, ffull, ovf_r};
            `ITTS_OFF_INPUTS:    rd_nxt[N-1:0] = data_out;
            `ITTS_OFF_FIFO_CNT:  rd_nxt[AW:0] = fcount;
            `ITTS_OFF_FIFO_INFO: rd_nxt = {fempty, 26'h0000000, head[EW-1], head[EW-2:TW]};
            `ITTS_OFF_FIFO_TIME: rd_nxt[TW-1:0] = head[TW-1:0];
            `ITTS_OFF_INT_STAT:  rd_nxt[`ITTS_INT_W-1:0] = int_stat_r;
            `ITTS_OFF_INT_EN:    rd_nxt[`ITTS_INT_W-1:0] = int_en_r;
            default:
            begin
                if (paddr >= `ITTS_OFF_TIME_BASE && paddr < `ITTS_OFF_TIME_BASE + 12'h080)
                begin
                    if (paddr[6])
                        rd_nxt[TW-1:0] = fall_ts_r[paddr[5:2]];
                    else
                        rd_nxt[TW-1:0] = rise_ts_r[paddr[5:2]];
                end
            end
        endcase
    end

    // apb slave: no wait state, answer registered; pop on a write to the pop register
    always @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            pop_r   <= 1'b0;
        end
        else
        begin
            pop_r   <= 1'b0;
            pslverr <= 1'b0;
            if (psel && !penable)
            begin
                pready <= 1'b1;
                prdata <= pwrite ? 32'h00000000 : rd_nxt;
                pslverr <= (paddr[1:0] != 2'b00);
            end
            else
                pready <= 1'b0;
            if (wr_acc && pready && paddr == `ITTS_OFF_FIFO_POP)
                pop_r <= 1'b1;
        end
    end
endmodule

// *** logic/itts_regs.vh ***
// Purpose: register map and constants of the input transition timestamper
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   offsets are byte addresses
`ifndef ITTS_REGS_VH
`define ITTS_REGS_VH

`define ITTS_OFF_CTRL       12'h000
`define ITTS_OFF_RISE_EN    12'h004
`define ITTS_OFF_FALL_EN    12'h008
`define ITTS_OFF_INTERVAL   12'h00C
`define ITTS_OFF_STATUS     12'h010
`define ITTS_OFF_INPUTS     12'h014
`define ITTS_OFF_FIFO_CNT   12'h018
`define ITTS_OFF_FIFO_POP   12'h01C
`define ITTS_OFF_FIFO_INFO  12'h020
`define ITTS_OFF_FIFO_TIME  12'h024
`define ITTS_OFF_INT_STAT   12'h028
`define ITTS_OFF_INT_EN     12'h02C
`define ITTS_OFF_INT_CLR    12'h030
`define ITTS_OFF_TIME_BASE  12'h100

`define ITTS_CTRL_MODE_BIT  0
`define ITTS_CTRL_APPLY_BIT 1
`define ITTS_MODE_PER_INPUT 1'b0
`define ITTS_MODE_QUEUED    1'b1

`define ITTS_INT_UPDATE_BIT 0
`define ITTS_INT_EVENT_BIT  1
`define ITTS_INT_OVF_BIT    2
`define ITTS_INT_W          3

`define ITTS_INTERVAL_RST   32'h0001E848
`define ITTS_FIFO_DEPTH     160

`endif

// *** logic/itts_fifo.v ***
// Purpose: arrival-order entry buffer of the queued mode
// Assumes: push is refused by the caller when full
// Notes:   flip-flop storage, index addressed
`timescale 1ns/1ns
module itts_fifo #(
    parameter WIDTH = 40,
    parameter DEPTH = 160,
    parameter AW    = 8
) (
    input  wire             core_clk_in,
    input  wire             nrst_in,
    input  wire             flush_in,
    input  wire             push_in,
    input  wire [WIDTH-1:0] push_data_in,
    input  wire             pop_in,
    output wire [WIDTH-1:0] head_out,
    output wire [AW:0]      count_out,
    output wire             full_out,
    output wire             empty_out
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0]    wr_r;
    reg [AW-1:0]    rd_r;
    reg [AW:0]      cnt_r;
    wire            do_push;
    wire            do_pop;
    integer         i;

    assign full_out  = (cnt_r == DEPTH[AW:0]);
    assign empty_out = (cnt_r == {(AW+1){1'b0}});
    assign do_push   = push_in & ~full_out;
    assign do_pop    = pop_in & ~empty_out;
    assign head_out  = mem_r[rd_r];
    assign count_out = cnt_r;

    // pointers wrap at depth, not at a power of two
    always @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            wr_r  <= {AW{1'b0}};
            rd_r  <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end
        else if (flush_in)
        begin
            wr_r  <= {AW{1'b0}};
            rd_r  <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end
        else
        begin
            if (do_push)
                wr_r <= (wr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_r + 1'b1;
            if (do_pop)
                rd_r <= (rd_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_r + 1'b1;
            if (do_push & ~do_pop)
                cnt_r <= cnt_r + 1'b1;
            else if (do_pop & ~do_push)
                cnt_r <= cnt_r - 1'b1;
        end
    end

    // storage holds no reset; head_out shows the unwritten entry at rd_r while the buffer is empty
    always @(posedge core_clk_in)
    begin
        for (i = 0; i < DEPTH; i = i + 1)
            if (do_push && wr_r == i[AW-1:0])
                mem_r[i] <= push_data_in;
    end
endmodule

// *** dv/itts_properties.sv ***
// Purpose: port-level properties of the timestamper
// Assumes: enables and interval are shadowed from APB writes
// Notes:   a gap counter bounds the periodic update
`timescale 1ns/1ns
`include "itts_regs.vh"
module itts_properties #(
    parameter N  = 16,
    parameter TW = 32
) (
    input wire          core_clk_in,
    input wire          nrst_in,
    input wire [N-1:0]  inputs_in,
    input wire [TW-1:0] system_time_stamp_in,
    input wire          psel,
    input wire          penable,
    input wire          pwrite,
    input wire [11:0]   paddr,
    input wire [31:0]   pwdata,
    input wire [31:0]   prdata,
    input wire          pready,
    input wire          pslverr,
    input wire [N-1:0]  data_out,
    input wire          data_update_out,
    input wire          irq_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!nrst_in);
    reg  [N-1:0] rise_en_r;
    reg  [N-1:0] fall_en_r;
    reg  [31:0]  ival_r;
    reg  [31:0]  gap_r;
    wire         wr_done = psel && penable && pready && pwrite;
    // shadow taken at the completing edge, as the design does
    always @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            rise_en_r <= {N{1'b1}};
            fall_en_r <= {N{1'b1}};
            ival_r    <= `ITTS_INTERVAL_RST;
        end
        else if (wr_done)
        begin
            if (paddr == `ITTS_OFF_RISE_EN) rise_en_r <= pwdata[N-1:0];
            if (paddr == `ITTS_OFF_FALL_EN) fall_en_r <= pwdata[N-1:0];
            if (paddr == `ITTS_OFF_CTRL && pwdata[1]) rise_en_r <= {N{1'b1}};
            if (paddr == `ITTS_OFF_CTRL && pwdata[1]) fall_en_r <= {N{1'b1}};
            if (paddr == `ITTS_OFF_INTERVAL) ival_r <= (pwdata == 32'h0) ? 32'h1 : pwdata;
        end
    end
    // restart on a new interval so a shortened one is not blamed
    always @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            gap_r <= 32'h0;
        else if (data_update_out || (wr_done && paddr == `ITTS_OFF_INTERVAL))
            gap_r <= 32'h0;
        else
            gap_r <= gap_r + 32'h1;
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence
    sequence s_en_edge;
        ((inputs_in & ~$past(inputs_in) & rise_en_r) | (~inputs_in & $past(inputs_in) & fall_en_r)) != 0;
    endsequence
    a_ready_setup: assert property (s_setup |=> pready)
        else $error("pready missing after setup");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    a_ready_single: assert property (s_access |=> !pready)
        else $error("pready held too long");
    a_err_misalign: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
        else $error("misaligned access not refused");
    a_err_aligned: assert property (pready && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("aligned access refused");
    a_write_rdata: assert property (pready && pwrite |-> prdata == 32'h0)
        else $error("read data driven on a write");
    a_edge_update: assert property (s_en_edge |-> ##[1:2] data_update_out)
        else $error("enabled change sent no update");
    a_data_snap: assert property (data_update_out |-> data_out == $past(inputs_in))
        else $error("update carries stale input data");
    a_update_gap: assert property (gap_r <= ival_r + 32'h2)
        else $error("periodic update overdue");
    a_reset_quiet: assert property ($rose(nrst_in) |-> !pready && !irq_out && !data_update_out)
        else $error("output active at reset release");
endmodule

// *** dv/itts_owner_model.sv ***
// Purpose: owner controller model taking input data broadcasts
// Assumes: one data_update_out pulse is one broadcast
// Notes:   keeps a count and the last snapshot
`timescale 1ns/1ns
module itts_owner_model #(
    parameter N = 16
) (
    input  wire         core_clk_in,
    input  wire         nrst_in,
    input  wire [N-1:0] data_in,
    input  wire         update_in,
    output reg  [31:0]  update_cnt_out,
    output reg  [N-1:0] last_data_out
);
    // every broadcast is accepted, whatever its cause
    always @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            update_cnt_out <= 32'h0;
            last_data_out  <= {N{1'b0}};
        end
        else if (update_in)
        begin
            update_cnt_out <= update_cnt_out + 32'h1;
            last_data_out  <= data_in;
        end
    end
endmodule

// *** dv/input_transition_timestamper_tb.sv ***
// Purpose: self-checking bench of the input transition timestamper
// Assumes: APB master with bounded waits; inputs toggle slowly
// Notes:   reads are checked by a monitor against queued notes
`timescale 1ns/1ns
`include "itts_regs.vh"
module input_transition_timestamper_tb;
    localparam [31:0] ALL = 32'hFFFFFFFF;
    reg          core_clk_in;
    reg          nrst_in;
    reg  [15:0]  inputs_in;
    reg  [31:0]  ts;
    reg          psel;
    reg          penable;
    reg          pwrite;
    reg  [11:0]  paddr;
    reg  [31:0]  pwdata;
    wire [31:0]  prdata;
    wire         pready;
    wire         pslverr;
    wire [15:0]  data_out;
    wire         data_update_out;
    wire         irq_out;
    wire [31:0]  upd_cnt;
    wire [15:0]  last_data;
    reg  [32:0]  exp_q[$];
    reg  [31:0]  msk_q[$];
    reg  [32:0]  e;
    reg  [31:0]  m;
    reg  [31:0]  t1;
    reg  [31:0]  t2;
    integer      failures;
    integer      tests_run;
    itts_top #(.N(16), .TW(32), .AW(8)) uut (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
        .inputs_in(inputs_in), .system_time_stamp_in(ts), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .data_out(data_out), .data_update_out(data_update_out), .irq_out(irq_out));
    itts_owner_model #(.N(16)) owner (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
        .data_in(data_out), .update_in(data_update_out), .update_cnt_out(upd_cnt), .last_data_out(last_data));
    initial
    begin
        core_clk_in = 1'b0;
        forever #4 core_clk_in = ~core_clk_in;
    end
    task give_verdict;
    begin
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask
    task chk(input string nm, input [32:0] ex, input [32:0] got);
    begin
        tests_run = tests_run + 1;
        if (got !== ex)
        begin
            failures = failures + 1;
            $display("Error %s expected %h seen %h", nm, ex, got);
        end
    end
    endtask
    // one transfer: setup, then access held until pready
    task apb(input w, input [11:0] a, input [31:0] d);
        integer n;
    begin
        @(posedge core_clk_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk_in);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge core_clk_in);
            n = n + 1;
        end while (pready !== 1'b1 && n < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
        begin
            failures = failures + 1;
            give_verdict;
        end
    end
    endtask
    // note the expectation first; misaligned places must be refused
    task rd(input [11:0] a, input [31:0] ex, input [31:0] mk);
    begin
        exp_q.push_back({a[1:0] != 2'b00, ex & mk});
        msk_q.push_back(mk);
        apb(1'b0, a, 32'h0);
    end
    endtask
    // toggle inputs with a fresh random time, then let the event settle
    task tg(input [15:0] mk);
    begin
        @(posedge core_clk_in);
        ts <= $urandom;
        inputs_in <= inputs_in ^ mk;
        repeat (3) @(posedge core_clk_in);
    end
    endtask
    // monitor: every completed read takes the oldest note
    always @(posedge core_clk_in)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            chk("prdata", e, {pslverr, prdata & m});
        end
    end
    initial
    begin
        {nrst_in, psel, penable, pwrite, paddr, pwdata, inputs_in, ts} = 0;
        failures = 0;
        tests_run = 0;
        t1 = $urandom(32'h7E77C7A9);
        repeat (5) @(posedge core_clk_in);
        nrst_in <= 1'b1;
        rd(`ITTS_OFF_CTRL, 32'h0, 32'h1);
        rd(`ITTS_OFF_RISE_EN, 32'hFFFF, 32'hFFFF);
        tg(16'h0008);
        t1 = ts;
        tg(16'h0008);
        rd(12'h10C, t1, ALL);
        rd(12'h14C, ts, ALL);
        tg(16'h0020);
        tg(16'h0020);
        t1 = ts;
        apb(1'b1, `ITTS_OFF_FALL_EN, 32'hFFDF);
        tg(16'h0020);
        t2 = ts;
        tg(16'h0020);
        rd(12'h114, t2, ALL);
        rd(12'h154, t1, ALL);
        tg(16'h0010);
        tg(16'h0018);
        rd(12'h10C, ts, ALL);
        rd(12'h150, ts, ALL);
        apb(1'b1, `ITTS_OFF_CTRL, 32'h1);
        tg(16'h0040);
        rd(12'h118, ts, ALL);
        rd(`ITTS_OFF_FIFO_CNT, 32'h0, ALL);
        apb(1'b1, `ITTS_OFF_CTRL, 32'h3);
        rd(`ITTS_OFF_CTRL, 32'h1, 32'h1);
        rd(`ITTS_OFF_FALL_EN, 32'hFFFF, 32'hFFFF);
        tg(16'h0001);
        t1 = ts;
        tg(16'h0001);
        tg(16'h0200);
        rd(`ITTS_OFF_FIFO_CNT, 32'h3, ALL);
        rd(`ITTS_OFF_FIFO_INFO, 32'h10, 32'h8000001F);
        rd(`ITTS_OFF_FIFO_TIME, t1, ALL);
        apb(1'b1, `ITTS_OFF_FIFO_POP, 32'h0);
        rd(`ITTS_OFF_FIFO_INFO, 32'h00, 32'h8000001F);
        apb(1'b1, `ITTS_OFF_FIFO_POP, 32'h0);
        rd(`ITTS_OFF_FIFO_INFO, 32'h19, 32'h8000001F);
        apb(1'b1, `ITTS_OFF_FIFO_POP, 32'h0);
        rd(`ITTS_OFF_FIFO_INFO, 32'h80000000, 32'h80000000);
        repeat (162) tg(16'h0080);
        rd(`ITTS_OFF_FIFO_CNT, 32'd160, ALL);
        rd(`ITTS_OFF_STATUS, 32'h3, 32'h3);
        rd(`ITTS_OFF_INT_STAT, 32'h4, 32'h4);
        repeat (160) apb(1'b1, `ITTS_OFF_FIFO_POP, 32'h0);
        @(posedge core_clk_in); // overflow flag drops one cycle after the buffer empties
        rd(`ITTS_OFF_STATUS, 32'h0, 32'h3);
        tg(16'h0080);
        rd(`ITTS_OFF_FIFO_CNT, 32'h1, ALL);
        apb(1'b1, `ITTS_OFF_INTERVAL, 32'd20);
        apb(1'b1, `ITTS_OFF_INT_CLR, 32'h7);
        t1 = upd_cnt;
        repeat (100) @(posedge core_clk_in);
        chk("updates", 33'd5, upd_cnt - t1);
        chk("snapshot", {17'h0, inputs_in}, {17'h0, last_data});
        rd(`ITTS_OFF_INT_STAT, 32'h1, 32'h1);
        apb(1'b1, `ITTS_OFF_INT_EN, 32'h1);
        repeat (2) @(posedge core_clk_in);
        chk("irq_out", 33'h1, {32'h0, irq_out});
        apb(1'b1, `ITTS_OFF_INT_EN, 32'h0);
        repeat (2) @(posedge core_clk_in);
        chk("irq_out", 33'h0, {32'h0, irq_out});
        rd(12'h0FC, 32'h0, ALL);
        rd(12'h002, 32'h0, 32'h0);
        repeat (3) @(posedge core_clk_in);
        give_verdict;
    end
endmodule
bind itts_top itts_properties #(.N(N), .TW(TW)) u_props (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .inputs_in(inputs_in), .system_time_stamp_in(system_time_stamp_in), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .data_out(data_out), .data_update_out(data_update_out), .irq_out(irq_out));
